// ===== design/fcs_flash_ctrl.sv
// Flash command controller: status, command, address, protection registers.
// Assumes one AHB-Lite master; the array algorithm engine sits outside.
// Summary of operation
// [R1] Protection may only grow, never shrink
// [R2] Disallowed scenario write is discarded entirely
// [R3] Fixed table of allowed scenario transitions
// [R4] Protection read returns active scenario
// [R5] Normal mode status bit access classes
// [R6] Special mode: fail writable, done read-only
// [R7] Buffer empty cleared only by writing one
// [R8] Zero to buffer empty mid-sequence aborts
// [R9] Interrupt on enabled buffer-empty or complete
// [R10] Complete clears on launch, sets when idle
// [R11] Protection violation sets, clears on one
// [R12] Access error on sequence, command, stop
// [R13] Blank set by verify, cleared on launch
// [R14] Special mode fail set by failed verify
// [R15] Done reads zero while operation active
// [R16] Command bits 6,5,2,0 only are writable
// [R17] Accepted codes 05, 20, 40, 41
// [R18] Other codes raise access error instead
// [R19] Factory test register reads zero
// [R20] Address register visible in special modes
// [R21] Sector erase ignores low ten address bits
// [R22] Software launches in three strict steps
// [R23] Buffer empty returns; second command waits
// [R24] No divider write means access error
// [R25] Scenario from open and disable bits
module fcs_flash_ctrl (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    input wire logic special_mode_in,
    input wire logic stop_exec_in,
    input wire logic array_done_in,
    input wire logic array_blank_in,
    input wire logic array_prot_hit_in,
    output logic array_start_out,
    output fcs_pkg::fcs_job_t array_job_out,
    output logic irq_out
);
    import fcs_pkg::*;
    logic sp_meta_q;
    logic sp_q;
    logic stop_meta_q;
    logic stop_q;
    logic wr_pend_q;
    logic [3:0] wr_idx_q;
    logic rd_valid_d;
    logic [31:0] rdata_q;
    logic [3:0] a_idx;
    logic a_take;
    logic wr_now;
    logic [7:0] wb;
    logic [7:0] prot_q;
    logic prot_ok;
    logic [7:0] cfg_q;
    logic [7:0] div_q;
    logic div_loaded_q;
    logic be_q;
    logic cc_q;
    logic pv_q;
    logic ae_q;
    logic blank_q;
    logic fail_q;
    logic [7:0] cmd_q;
    logic [15:0] addr_q;
    logic [15:0] data_q;
    logic busy;
    logic buf_full;
    logic start;
    fcs_job_t active;
    fcs_job_t new_job;
    logic is_status_wr;
    logic launch;
    logic abort;
    logic seq_err;
    logic bad_cmd;
    logic no_div;
    logic blocked;
    logic set_ae;
    logic verify_end;
    logic [7:0] status_rd;
    logic [7:0] rd_byte;

    // Sequence steps; a data write or a zero to buffer empty mid-sequence aborts it
    typedef enum logic [1:0] {
        SEQ_IDLE = 2'h0,
        SEQ_ADDR = 2'h1,
        SEQ_CMD = 2'h2
    } fcs_seq_t;
    fcs_seq_t seq_q;

    // Mode and stop come from outside this clock domain
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            sp_meta_q <= 1'b0;
            sp_q <= 1'b0;
            stop_meta_q <= 1'b0;
            stop_q <= 1'b0;
        end else begin
            sp_meta_q <= special_mode_in;
            sp_q <= sp_meta_q;
            stop_meta_q <= stop_exec_in;
            stop_q <= stop_meta_q;
        end
    end

    // Bus slave: zero wait states, always OKAY
    assign a_take = hsel_in && hready_in && htrans_in[1];
    assign a_idx = haddr_in[ADDR_LSB +: 4];
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            wr_pend_q <= 1'b0;
            wr_idx_q <= '0;
        end else begin
            wr_pend_q <= a_take && hwrite_in;
            wr_idx_q <= a_idx;
        end
    end
    assign wr_now = wr_pend_q;
    assign wb = hwdata_in[7:0];
    assign hreadyout_out = 1'b1;
    assign hresp_out = 1'b0;
    assign rd_valid_d = a_take && !hwrite_in;
    assign is_status_wr = wr_now && wr_idx_q == IDX_STATUS;

    // Flash data space modelled as data register, write is step one
    assign seq_err = wr_now && seq_q != SEQ_IDLE && wr_idx_q == IDX_DATA;
    assign launch = is_status_wr && wb[ST_BE] && be_q && seq_q == SEQ_CMD;
    assign abort = is_status_wr && !wb[ST_BE] && seq_q != SEQ_IDLE; // see [R8]
    assign bad_cmd = cmd_q != FCS_CMD_VERIFY && cmd_q != FCS_CMD_PROG
        && cmd_q != FCS_CMD_SECT && cmd_q != FCS_CMD_MASS; // see [R17] [R18]
    assign no_div = !div_loaded_q; // see [R24]
    assign blocked = pv_q || ae_q || (sp_q && fail_q); // see [R11] [R14]
    assign set_ae = abort || seq_err || (stop_q && busy) // see [R12]
        || (launch && (bad_cmd || no_div));
    assign new_job.cmd = cmd_q;
    assign new_job.addr = (cmd_q == FCS_CMD_SECT) ? (addr_q & SECTOR_MASK) : addr_q; // see [R21]
    assign new_job.data = data_q;

    // Command write sequence tracking
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            seq_q <= SEQ_IDLE;
            cmd_q <= '0;
            addr_q <= '0;
            data_q <= '0;
        end else if (abort || launch || seq_err) begin
            seq_q <= SEQ_IDLE;
        end else if (wr_now && wr_idx_q == IDX_DATA && be_q && !blocked) begin
            seq_q <= SEQ_ADDR;
            data_q <= hwdata_in[15:0];
            addr_q <= hwdata_in[31:16];
        end else if (wr_now && wr_idx_q == IDX_CMD && seq_q == SEQ_ADDR) begin
            seq_q <= SEQ_CMD;
            cmd_q <= wb & CMD_MASK; // see [R16]
        end else if (wr_now && wr_idx_q == IDX_ADDR && sp_q) begin
            addr_q <= hwdata_in[15:0]; // see [R20]
        end
    end

    logic go;
    assign go = launch && !bad_cmd && !no_div && !blocked;

    fcs_job_engine u_engine (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .launch_in(go),
        .job_in(new_job),
        .array_done_in(array_done_in),
        .busy_out(busy),
        .buf_full_out(buf_full),
        .start_out(start),
        .active_out(active)
    );
    assign array_start_out = start;
    assign array_job_out = active;
    assign verify_end = array_done_in && active.cmd == FCS_CMD_VERIFY;

    // Buffer empty and complete flags
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            be_q <= 1'b1;
            cc_q <= 1'b1;
        end else begin
            if (go) begin
                be_q <= 1'b0; // see [R7]
            end else if (!be_q && !buf_full) begin
                be_q <= 1'b1; // see [R23]
            end
            if (go) begin
                cc_q <= 1'b0; // see [R10]
            end else if (!busy && be_q) begin
                cc_q <= 1'b1; // see [R10]
            end
        end
    end

    // Error flags: hardware set wins over a software clear
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            pv_q <= 1'b0;
            ae_q <= 1'b0;
            fail_q <= 1'b0;
            blank_q <= 1'b0;
        end else begin
            if (array_prot_hit_in && start) begin
                pv_q <= 1'b1; // see [R11]
            end else if (is_status_wr && wb[ST_PV]) begin
                pv_q <= 1'b0;
            end
            if (set_ae) begin
                ae_q <= 1'b1; // see [R12]
            end else if (is_status_wr && wb[ST_AE]) begin
                ae_q <= 1'b0;
            end
            if (sp_q && verify_end && !array_blank_in) begin
                fail_q <= 1'b1; // see [R14]
            end else if (is_status_wr && wb[ST_FAIL] && sp_q) begin
                fail_q <= 1'b0; // see [R6]
            end
            if (verify_end && array_blank_in) begin
                blank_q <= 1'b1; // see [R13]
            end else if (go) begin
                blank_q <= 1'b0; // see [R13]
            end
        end
    end

    // Protection, config and divider registers
    fcs_prot_filter u_filter (
        .cur_in(prot_q),
        .req_in(wb),
        .allow_out(prot_ok)
    );
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            prot_q <= PROT_RESET;
        end else if (wr_now && wr_idx_q == IDX_PROT && prot_ok) begin
            prot_q <= wb; // see [R1] [R2]
        end
    end
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            cfg_q <= '0;
            div_q <= '0;
            div_loaded_q <= 1'b0;
        end else if (wr_now && wr_idx_q == IDX_CONFIG) begin
            cfg_q <= wb;
        end else if (wr_now && wr_idx_q == IDX_CLKDIV) begin
            div_q <= wb;
            div_loaded_q <= 1'b1; // see [R24]
        end
    end

    assign irq_out = (be_q && cfg_q[CF_BEIE]) || (cc_q && cfg_q[CF_COMPLETE_IRQ_ENABLE]); // see [R9]

    // Read mux
    always_comb begin
        status_rd = '0;
        status_rd[ST_BE] = be_q; // see [R5]
        status_rd[ST_CC] = cc_q;
        status_rd[ST_PV] = pv_q;
        status_rd[ST_AE] = ae_q;
        status_rd[ST_BLANK] = blank_q;
        status_rd[ST_FAIL] = sp_q && fail_q; // see [R6]
        status_rd[ST_DONE] = sp_q && !busy; // see [R15]
        case (a_idx)
            IDX_CLKDIV: rd_byte = {div_loaded_q, div_q[6:0]};
            IDX_CONFIG: rd_byte = cfg_q;
            IDX_PROT: rd_byte = prot_q; // see [R4]
            IDX_STATUS: rd_byte = status_rd;
            IDX_CMD: rd_byte = (seq_q == SEQ_CMD) ? cmd_q : 8'h00;
            IDX_TEST: rd_byte = 8'h00; // see [R19]
            IDX_MODE: rd_byte = {7'h00, sp_q};
            default: rd_byte = 8'h00;
        endcase
    end
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            rdata_q <= '0;
        end else if (rd_valid_d) begin
            if (a_idx == IDX_ADDR) begin
                rdata_q <= sp_q ? {16'h0000, addr_q} : 32'h0000_0000; // see [R20]
            end else begin
                rdata_q <= {24'h00_0000, rd_byte};
            end
        end
    end
    assign hrdata_out = rdata_q;

    AST_PROT_FILTER: assert property (@(posedge clk_in) disable iff (!reset_n_in) // see [R2]
        (wr_now && wr_idx_q == IDX_PROT && !prot_ok) |=> $stable(prot_q))
        else $error("protection changed on a refused write");
    AST_BE_ZERO: assert property (@(posedge clk_in) disable iff (!reset_n_in) // see [R7]
        (is_status_wr && !wb[ST_BE] && be_q) |=> be_q)
        else $error("buffer empty cleared by a zero");
    AST_ABORT_AE: assert property (@(posedge clk_in) disable iff (!reset_n_in) // see [R8]
        abort |=> ae_q)
        else $error("abort did not raise access error");
    // Watches the output equation, not the flags behind the request
    AST_IRQ: assert property (@(posedge clk_in) disable iff (!reset_n_in) // see [R9]
        (go && !cfg_q[CF_BEIE]) |=> !irq_out)
        else $error("interrupt still requested after launch");
    AST_LAUNCH_CC: assert property (@(posedge clk_in) disable iff (!reset_n_in) // see [R10]
        go |=> !cc_q ##1 !cc_q)
        else $error("complete flag not cleared on launch");
    AST_CC_BUSY: assert property (@(posedge clk_in) disable iff (!reset_n_in) // see [R10]
        busy |-> !cc_q)
        else $error("complete flag set while a command is pending");
    AST_BAD_CMD: assert property (@(posedge clk_in) disable iff (!reset_n_in) // see [R18]
        (launch && bad_cmd) |=> ae_q && !$rose(busy))
        else $error("illegal command not refused");
    AST_NO_DIV: assert property (@(posedge clk_in) disable iff (!reset_n_in) // see [R24]
        (launch && no_div) |=> ae_q)
        else $error("launch without divider accepted");
    AST_BLOCKED: assert property (@(posedge clk_in) disable iff (!reset_n_in) // see [R11] [R12]
        (pv_q || ae_q) |=> !$rose(buf_full))
        else $error("launch while error flag set");
    AST_TEST_ZERO: assert property (@(posedge clk_in) disable iff (!reset_n_in) // see [R19]
        (rd_valid_d && a_idx == IDX_TEST) |=> rdata_q == 32'h0000_0000)
        else $error("factory test register not zero");
    AST_SECT_ADDR: assert property (@(posedge clk_in) disable iff (!reset_n_in) // see [R21]
        (start && active.cmd == FCS_CMD_SECT) |-> (active.addr & ~SECTOR_MASK) == 16'h0000)
        else $error("sector erase address not masked");
    COV_LAUNCH: cover property (@(posedge clk_in) disable iff (!reset_n_in) go);
    COV_BUFFERED: cover property (@(posedge clk_in) disable iff (!reset_n_in)
        go && busy);
    COV_PROT_REFUSED: cover property (@(posedge clk_in) disable iff (!reset_n_in)
        wr_now && wr_idx_q == IDX_PROT && !prot_ok);
    COV_ABORT: cover property (@(posedge clk_in) disable iff (!reset_n_in) abort);
    COV_VERIFY_FAIL: cover property (@(posedge clk_in) disable iff (!reset_n_in)
        sp_q && verify_end && !array_blank_in);
endmodule : fcs_flash_ctrl

// ===== design/fcs_pkg.sv
// Package for the flash command, status and protection block.
// Assumes an AHB-Lite master with 32-bit single word transfers.
package fcs_pkg;
    // Printed offsets are not all multiples of four: kept as indices
    localparam logic [3:0] IDX_CLKDIV = 4'h0;
    localparam logic [3:0] IDX_CONFIG = 4'h3;
    localparam logic [3:0] IDX_PROT = 4'h4;
    localparam logic [3:0] IDX_STATUS = 4'h5;
    localparam logic [3:0] IDX_CMD = 4'h6;
    localparam logic [3:0] IDX_TEST = 4'h7;
    localparam logic [3:0] IDX_ADDR = 4'h8;
    localparam logic [3:0] IDX_DATA = 4'ha;
    localparam logic [3:0] IDX_MODE = 4'hb;
    localparam int ADDR_LSB = 2;
    // Status bit positions
    localparam int ST_BE = 7;
    localparam int ST_CC = 6;
    localparam int ST_PV = 5;
    localparam int ST_AE = 4;
    localparam int ST_BLANK = 2;
    localparam int ST_FAIL = 1;
    localparam int ST_DONE = 0;
    // Config bit positions
    localparam int CF_BEIE = 7;
    localparam int CF_COMPLETE_IRQ_ENABLE = 6;
    // Protection bit positions
    localparam int PR_OPEN = 7;
    localparam int PR_HDIS = 5;
    localparam int PR_LDIS = 2;
    localparam logic [7:0] CMD_MASK = 8'h65;
    localparam logic [7:0] PROT_RESET = 8'hff;
    localparam logic [15:0] FLASH_BASE = 16'h4000;
    localparam logic [15:0] SECTOR_MASK = 16'hfc00;
    typedef enum logic [7:0] {
        FCS_CMD_VERIFY = 8'h05,
        FCS_CMD_PROG = 8'h20,
        FCS_CMD_SECT = 8'h40,
        FCS_CMD_MASS = 8'h41
    } fcs_cmd_t;
    typedef struct packed {
        logic [7:0] cmd;
        logic [15:0] addr;
        logic [15:0] data;
    } fcs_job_t;
endpackage : fcs_pkg

// ===== design/fcs_prot_filter.sv
// Protection scenario filter: decides whether a protection write may land.
// Assumes the caller supplies the current and requested register values.
module fcs_prot_filter (
    input wire logic [7:0] cur_in,
    input wire logic [7:0] req_in,
    output logic allow_out
);
    import fcs_pkg::*;
    logic [2:0] cur_s;
    logic [2:0] req_s;
    logic [7:0] ok_row;
    // Scenario 7 unprotected, 3 fully locked
    function automatic logic [2:0] scen(input logic [7:0] p);
        scen = {p[PR_OPEN], p[PR_HDIS], p[PR_LDIS]}; // see [R25]
    endfunction : scen
    always_comb begin
        cur_s = scen(cur_in);
        req_s = scen(req_in);
        case (cur_s) // see [R3]
            3'h0: ok_row = 8'h0f;
            3'h1: ok_row = 8'h0a;
            3'h2: ok_row = 8'h0c;
            3'h3: ok_row = 8'h08;
            3'h4: ok_row = 8'h18;
            3'h5: ok_row = 8'h3c;
            3'h6: ok_row = 8'h5a;
            3'h7: ok_row = 8'hff;
            default: ok_row = 8'h00;
        endcase
        allow_out = ok_row[req_s]; // see [R1] [R2]
    end
endmodule : fcs_prot_filter

// ===== design/fcs_job_engine.sv
// Two-stage command pipe: a buffered job waits for the active one.
// Assumes an outside array engine signals done for each started job.
module fcs_job_engine (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic launch_in,
    input wire fcs_pkg::fcs_job_t job_in,
    input wire logic array_done_in,
    output logic busy_out,
    output logic buf_full_out,
    output logic start_out,
    output fcs_pkg::fcs_job_t active_out
);
    import fcs_pkg::*;
    logic act_q;
    logic buf_q;
    fcs_job_t buf_job_q;
    fcs_job_t act_job_q;
    logic start_q;
    logic take_buf;
    assign take_buf = buf_q && (!act_q || array_done_in); // see [R23]
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            act_q <= 1'b0;
            start_q <= 1'b0;
            act_job_q <= '0;
        end else begin
            start_q <= take_buf;
            if (take_buf) begin
                act_q <= 1'b1;
                act_job_q <= buf_job_q;
            end else if (array_done_in) begin
                act_q <= 1'b0;
            end
        end
    end
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            buf_q <= 1'b0;
            buf_job_q <= '0;
        end else if (launch_in) begin
            buf_q <= 1'b1;
            buf_job_q <= job_in;
        end else if (take_buf) begin
            buf_q <= 1'b0;
        end
    end
    assign busy_out = act_q || buf_q;
    assign buf_full_out = buf_q;
    assign start_out = start_q;
    assign active_out = act_job_q;
endmodule : fcs_job_engine

// ===== verification/fcs_array_model.sv
// Array engine model: answers each start pulse with one done pulse.
// Assumes the controller samples hit on the start cycle, blank with done.
module fcs_array_model (
    input wire logic clk_in,
    input wire logic start_in,
    input wire logic [7:0] delay_in,
    input wire logic blank_in,
    input wire logic hit_in,
    output logic done_out,
    output logic blank_out,
    output logic hit_out
);
    timeunit 1ns;
    timeprecision 100ps;
    int cnt = 0;
    initial done_out = 1'b0;
    // Outside their valid cycle the levels show the inverse, not stale data
    assign hit_out = start_in ? hit_in : ~hit_in;
    assign blank_out = done_out ? blank_in : ~blank_in;
    // Done even on a protected start, so a hit never hangs the pipe
    always @(posedge clk_in) begin
        done_out <= (cnt == 1);
        if (start_in) begin
            cnt <= int'(delay_in) + 2;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end
    end
endmodule : fcs_array_model

// ===== verification/fcs_flash_ctrl_bench.sv
// Self-checking bench for the flash command controller.
// Assumes one AHB-Lite master (this bench) and the array engine model.
module fcs_flash_ctrl_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import fcs_pkg::*;
    logic clk_in, reset_n_in, hwrite, special, stop, rd_dp, blank, hit;
    logic [31:0] haddr, hwdata, hrdata_out;
    logic [1:0] htrans;
    logic hreadyout_out, hresp_out, array_start_out, irq_out;
    logic done_w, blank_w, hit_w;
    fcs_job_t array_job_out;
    logic [7:0] dly, last;
    logic [2:0] cur, s;
    logic [15:0] rd_e;
    logic [15:0] rd_q[$];
    logic [39:0] job_q[$];
    int error_cnt = 0;
    int compares = 0;
    int seed = 32'h67df;
    logic [7:0] allow [8] = '{8'h0f, 8'h0a, 8'h0c, 8'h08, 8'h18, 8'h3c, 8'h5a, 8'hff};
    logic [7:0] codes [4] = '{FCS_CMD_VERIFY, FCS_CMD_PROG, FCS_CMD_SECT, FCS_CMD_MASS};
    logic [7:0] cfgs [4] = '{8'hc0, 8'h80, 8'h40, 8'h00};

    fcs_flash_ctrl u_dut (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .hsel_in(1'b1),
        .haddr_in(haddr),
        .htrans_in(htrans),
        .hwrite_in(hwrite),
        .hsize_in(3'b010),
        .hwdata_in(hwdata),
        .hready_in(hreadyout_out),
        .hrdata_out(hrdata_out),
        .hreadyout_out(hreadyout_out),
        .hresp_out(hresp_out),
        .special_mode_in(special),
        .stop_exec_in(stop),
        .array_done_in(done_w),
        .array_blank_in(blank_w),
        .array_prot_hit_in(hit_w),
        .array_start_out(array_start_out),
        .array_job_out(array_job_out),
        .irq_out(irq_out)
    );

    fcs_array_model u_array (
        .clk_in(clk_in),
        .start_in(array_start_out),
        .delay_in(dly),
        .blank_in(blank),
        .hit_in(hit),
        .done_out(done_w),
        .blank_out(blank_w),
        .hit_out(hit_w)
    );

    initial begin
        clk_in = 1'b0;
        forever #12.5 clk_in = ~clk_in;
    end

    task automatic summarize;
        $display("compares %0d errors %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : summarize

    task automatic chk(input string nm, input logic [39:0] e, input logic [39:0] g);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic edge_rdy;
        int n;
        n = 0;
        @(posedge clk_in);
        while (hreadyout_out !== 1'b1) begin
            n++;
            if (n > 50) begin
                error_cnt++;
                summarize;
            end
            @(posedge clk_in);
        end
    endtask : edge_rdy

    // Not pipelined: the next address phase waits for this data phase
    task automatic bus(input logic w, input logic [3:0] i, input logic [31:0] d,
                       input logic q);
        haddr <= {26'h0, i, 2'b00};
        hwrite <= w;
        htrans <= 2'b10;
        edge_rdy;
        htrans <= 2'b00;
        hwdata <= d;
        rd_dp <= q;
        edge_rdy;
        last = hrdata_out[7:0];
        rd_dp <= 1'b0;
    endtask : bus

    task automatic wr(input logic [3:0] i, input logic [31:0] d);
        bus(1'b1, i, d, 1'b0);
    endtask : wr

    task automatic rd(input logic [3:0] i, input logic [7:0] m, input logic [7:0] e);
        rd_q.push_back({m, e});
        bus(1'b0, i, 32'h0, 1'b1);
    endtask : rd

    task automatic poll(input logic [7:0] m, input logic [7:0] e);
        int n;
        n = 0;
        bus(1'b0, IDX_STATUS, 32'h0, 1'b0);
        while ((last & m) !== e) begin
            n++;
            if (n > 60) begin
                chk("status poll", e, last & m);
                summarize;
            end
            bus(1'b0, IDX_STATUS, 32'h0, 1'b0);
        end
    endtask : poll

    task automatic launch(input logic [7:0] c, input logic ok, input logic rb);
        logic [15:0] a;
        logic [15:0] dv;
        a = 16'h4000 | 16'($random(seed) & 32'h3fff);
        dv = 16'($random(seed));
        wr(IDX_DATA, {a, dv});
        wr(IDX_CMD, {24'h0, c});
        if (rb) begin
            rd(IDX_CMD, 8'hff, c & CMD_MASK);
        end
        wr(IDX_STATUS, 32'h80);
        if (ok) begin
            job_q.push_back({c, (c == FCS_CMD_SECT) ? (a & SECTOR_MASK) : a, dv});
        end
    endtask : launch

    task automatic rst;
        reset_n_in <= 1'b0;
        repeat (6) @(posedge clk_in);
        reset_n_in <= 1'b1;
        @(posedge clk_in);
    endtask : rst

    always @(posedge clk_in) begin
        if (rd_dp && hreadyout_out === 1'b1) begin
            rd_e = rd_q.pop_front();
            chk("read data", rd_e[7:0], hrdata_out[7:0] & rd_e[15:8]);
            chk("response", 1'b0, hresp_out);
        end
        if (array_start_out === 1'b1) begin
            if (job_q.size() == 0) begin
                chk("unexpected start", 1'b0, 1'b1);
            end else begin
                chk("active job", job_q.pop_front(), array_job_out);
            end
        end
    end

    initial begin
        repeat (60000) @(posedge clk_in);
        error_cnt++;
        summarize;
    end

    initial begin
        reset_n_in = 1'b0;
        haddr = 32'h0;
        hwdata = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        rd_dp = 1'b0;
        special = 1'b0;
        stop = 1'b0;
        blank = 1'b1;
        hit = 1'b0;
        dly = 8'd20;
        rst;
        rd(IDX_STATUS, 8'hff, 8'hc0);
        rd(IDX_PROT, 8'hff, PROT_RESET);
        wr(IDX_TEST, 32'hff);
        rd(IDX_TEST, 8'hff, 8'h00);
        wr(IDX_ADDR, 32'h5a);
        rd(IDX_ADDR, 8'hff, 8'h00);
        rd(4'hf, 8'hff, 8'h00);
        wr(IDX_STATUS, 32'h00);
        rd(IDX_STATUS, 8'h90, 8'h80);
        foreach (cfgs[k]) begin
            wr(IDX_CONFIG, {24'h0, cfgs[k]});
            @(posedge clk_in);
            chk("irq", cfgs[k] != 8'h00, irq_out);
        end
        // Random walks; a reset reopens scenario 7 between rounds
        for (int r = 0; r < 3; r++) begin
            cur = 3'd7;
            for (int k = 0; k < 8; k++) begin
                s = 3'($random(seed));
                wr(IDX_PROT, {24'h0, s[2], 1'b1, s[1], 2'b11, s[0], 2'b11});
                if (allow[cur][s]) cur = s;
                rd(IDX_PROT, 8'ha4, {cur[2], 1'b0, cur[1], 2'b00, cur[0], 2'b00});
            end
            rst;
        end
        launch(FCS_CMD_PROG, 1'b0, 1'b1);
        rd(IDX_STATUS, 8'h10, 8'h10);
        wr(IDX_STATUS, 32'h10);
        rd(IDX_STATUS, 8'h10, 8'h00);
        wr(IDX_CLKDIV, 32'h04);
        launch(8'hff, 1'b0, 1'b1);
        rd(IDX_STATUS, 8'h10, 8'h10);
        wr(IDX_STATUS, 32'h10);
        wr(IDX_DATA, 32'h4000_1234);
        wr(IDX_STATUS, 32'h00);
        rd(IDX_STATUS, 8'h10, 8'h10);
        wr(IDX_STATUS, 32'h10);
        foreach (codes[k]) begin
            launch(codes[k], 1'b1, 1'b1);
            rd(IDX_STATUS, 8'h40, 8'h00);
            poll(8'h40, 8'h40);
            rd(IDX_STATUS, 8'hc4, (k == 0) ? 8'hc4 : 8'hc0);
        end
        wr(IDX_CONFIG, 32'h40);
        launch(FCS_CMD_PROG, 1'b1, 1'b0);
        poll(8'h80, 8'h80);
        launch(FCS_CMD_PROG, 1'b1, 1'b0);
        rd(IDX_STATUS, 8'h40, 8'h00);
        chk("irq", 1'b0, irq_out);
        poll(8'hc0, 8'hc0);
        chk("irq", 1'b1, irq_out);
        hit <= 1'b1;
        launch(FCS_CMD_SECT, 1'b1, 1'b1);
        poll(8'h40, 8'h40);
        rd(IDX_STATUS, 8'h20, 8'h20);
        launch(FCS_CMD_PROG, 1'b0, 1'b0);
        rd(IDX_STATUS, 8'h40, 8'h40);
        wr(IDX_STATUS, 32'h30);
        rd(IDX_STATUS, 8'h30, 8'h00);
        hit <= 1'b0;
        dly <= 8'd40;
        launch(FCS_CMD_PROG, 1'b1, 1'b0);
        stop <= 1'b1;
        repeat (4) @(posedge clk_in);
        stop <= 1'b0;
        poll(8'h40, 8'h40);
        rd(IDX_STATUS, 8'h10, 8'h10);
        wr(IDX_STATUS, 32'h10);
        special <= 1'b1;
        repeat (4) @(posedge clk_in);
        wr(IDX_ADDR, 32'h5a);
        rd(IDX_ADDR, 8'hff, 8'h5a);
        rd(IDX_STATUS, 8'h03, 8'h01);
        blank <= 1'b0;
        launch(FCS_CMD_VERIFY, 1'b1, 1'b1);
        rd(IDX_STATUS, 8'h01, 8'h00);
        poll(8'h40, 8'h40);
        rd(IDX_STATUS, 8'h07, 8'h03);
        launch(FCS_CMD_PROG, 1'b0, 1'b0);
        rd(IDX_STATUS, 8'h40, 8'h40);
        wr(IDX_STATUS, 32'h32);
        rd(IDX_STATUS, 8'h32, 8'h00);
        repeat (50) @(posedge clk_in);
        chk("jobs left", 40'h0, 40'(job_q.size()));
        summarize;
    end
endmodule : fcs_flash_ctrl_bench
